// File: include/fps_pkg.sv
// constants, states and register map of the flash programmer status block
package fps_pkg;
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned OSC_MS = 10;
    localparam int unsigned SETUP_MS = 10;
    localparam int unsigned OSC_CYCLES = OSC_MS * CLK_KHZ;
    localparam int unsigned SETUP_CYCLES = SETUP_MS * CLK_KHZ;
    localparam int unsigned TMR_W = 22;

    // command codes are arbitrary, chosen for this block
    localparam logic [7:0] CMD_MREAD = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_STAT = 8'h71;

    localparam int unsigned ST_ABN = 7;
    localparam int unsigned ST_CMDERR = 6;
    localparam int unsigned ST_PROGF = 5;
    localparam int unsigned ST_ERASEF = 4;
    localparam int unsigned ST_COUNTF = 1;
    localparam int unsigned ST_ADDRF = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // fault inputs from the array sequencer: {program, erase, count, address}
    localparam int unsigned FLT_W = 4;

    localparam logic [1:0] REG_IRQ_STAT = 2'h0;
    localparam logic [1:0] REG_IRQ_MASK = 2'h1;
    localparam logic [1:0] REG_POLL = 2'h2;
    localparam int unsigned EV_N = 4;
    localparam int unsigned EV_READY = 0;
    localparam int unsigned EV_DONE = 1;
    localparam int unsigned EV_FAIL = 2;
    localparam int unsigned EV_IGNORED = 3;
    localparam logic [3:0] MASK_RST = 4'h0;

    typedef enum logic [4:0] {
        MODE_WAIT = 5'h01,
        MODE_MREAD = 5'h02,
        MODE_PROG = 5'h04,
        MODE_ERASE = 5'h08,
        MODE_STAT = 5'h10
    } fps_mode_t;
endpackage

// File: include/fps_if.sv
// bundle between the start-up timer and the command logic
`timescale 1ns/1ps
`default_nettype none
interface fps_if;
    logic oscDone;
    logic setupDone;
    modport timer (output oscDone, output setupDone);
    modport user (input oscDone, input setupDone);
endinterface
`default_nettype wire

// File: verilog/fps_timer.sv
// oscillator stabilisation and programmer mode setup timer
`timescale 1ns/1ps
`default_nettype none
module fps_timer #(
    parameter int unsigned OSC_CYCLES = fps_pkg::OSC_CYCLES,
    parameter int unsigned SETUP_CYCLES = fps_pkg::SETUP_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    fps_if.timer tmr
);
    logic [fps_pkg::TMR_W-1:0] cnt_ff;
    logic oscDone_ff;
    logic setupDone_ff;

    // the same counter serves both phases, restarting between them
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_ff <= '0;
            oscDone_ff <= 1'b0;
            setupDone_ff <= 1'b0;
        end else if (!oscDone_ff) begin
            if (cnt_ff == fps_pkg::TMR_W'(OSC_CYCLES - 1)) begin // [RULE7]
                oscDone_ff <= 1'b1;
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end else if (!setupDone_ff) begin
            if (cnt_ff == fps_pkg::TMR_W'(SETUP_CYCLES - 1)) begin // [RULE8]
                setupDone_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign tmr.oscDone = oscDone_ff;
    assign tmr.setupDone = setupDone_ff;
endmodule
`default_nettype wire

// File: verilog/fps_status.sv
// programmer-mode command, polling and status reporting for the flash array
// Behaviour
// [RULE1] programmer waits 20 us after status read command before reading
// [RULE2] status byte: 7 abnormal, 6 command, 5 program, 4 erase, 1 count, 0 address
// [RULE3] done pin shows whether auto program or erase is still running
// [RULE4] result pin separates good completion from failed completion
// [RULE5] polling: running 00, normal end 11, abnormal end one high, low six zero
// [RULE6] commands during oscillator or setup period are ignored
// [RULE7] programmer allows 10 ms oscillator stabilisation after standby release
// [RULE8] after 10 ms setup the device enters memory read and takes commands
// [RULE9] programmer erases before reprogramming an already programmed address
// [RULE10] erase recommended before PROM programming of on-board programmed chips
// [RULE11] each address block is programmed once only between erases
// [RULE12] erase recommended first for chips with unknown erase history
// [RULE13] polling flags hold until the next command write
// [RULE14] programmer writes no command while auto program runs
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fps_status #(
    parameter int unsigned OSC_CYCLES = fps_pkg::OSC_CYCLES,
    parameter int unsigned SETUP_CYCLES = fps_pkg::SETUP_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOeN,
    input wire logic [7:0] arrayData,
    output logic progStart,
    output logic eraseStart,
    input wire logic coreDone,
    input wire logic [fps_pkg::FLT_W-1:0] coreFaults,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic irq
);
    fps_if tmr ();

    fps_timer #(.OSC_CYCLES(OSC_CYCLES), .SETUP_CYCLES(SETUP_CYCLES)) u_timer (
        .clock(clock),
        .nrst(nrst),
        .tmr(tmr)
    );

    function automatic logic isAuto(input logic [7:0] cmd);
        isAuto = (cmd == fps_pkg::CMD_PROG) || (cmd == fps_pkg::CMD_ERASE);
    endfunction

    function automatic logic isKnown(input logic [7:0] cmd);
        isKnown = isAuto(cmd) || (cmd == fps_pkg::CMD_MREAD) || (cmd == fps_pkg::CMD_STAT);
    endfunction

    fps_pkg::fps_mode_t mode_ff;
    logic weN_ff;
    logic busy_ff;
    logic done_ff;
    logic result_ff;
    logic [7:0] status_ff;
    logic [7:0] dataOut_ff;
    logic dataOeN_ff;
    logic progStart_ff;
    logic eraseStart_ff;
    logic [7:0] regRdData_ff;
    logic irq_ff;
    logic [fps_pkg::EV_N-1:0] evStat_ff;
    logic [fps_pkg::EV_N-1:0] evMask_ff;
    logic [fps_pkg::EV_N-1:0] events;

    logic pinRd;
    logic wrEdge;
    logic accepting;
    logic cmdWr;
    logic anyFault;
    logic finish;
    logic statRdClr;

    assign pinRd = !ceN && !oeN;
    assign wrEdge = weN_ff && !weN && !ceN;
    // a write while waiting or while the array is busy is dropped
    assign accepting = (mode_ff != fps_pkg::MODE_WAIT) && !busy_ff; // [RULE6] [RULE14]
    assign cmdWr = wrEdge && accepting;
    assign anyFault = |coreFaults;
    assign finish = busy_ff && coreDone;
    assign statRdClr = regRd && (regAddr == fps_pkg::REG_IRQ_STAT);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            weN_ff <= 1'b1;
        end else begin
            weN_ff <= weN;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mode_ff <= fps_pkg::MODE_WAIT;
        end else begin
            case (mode_ff)
                fps_pkg::MODE_WAIT: begin
                    if (tmr.setupDone) begin
                        mode_ff <= fps_pkg::MODE_MREAD; // [RULE8]
                    end
                end
                fps_pkg::MODE_MREAD, fps_pkg::MODE_PROG, fps_pkg::MODE_ERASE,
                fps_pkg::MODE_STAT: begin
                    if (cmdWr) begin
                        case (dataIn)
                            fps_pkg::CMD_MREAD: mode_ff <= fps_pkg::MODE_MREAD;
                            fps_pkg::CMD_PROG: mode_ff <= fps_pkg::MODE_PROG;
                            fps_pkg::CMD_ERASE: mode_ff <= fps_pkg::MODE_ERASE;
                            // an unknown code leaves the status byte on the pins
                            default: mode_ff <= fps_pkg::MODE_STAT;
                        endcase
                    end
                end
                default: mode_ff <= fps_pkg::MODE_WAIT;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            progStart_ff <= 1'b0;
            eraseStart_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            progStart_ff <= cmdWr && (dataIn == fps_pkg::CMD_PROG);
            eraseStart_ff <= cmdWr && (dataIn == fps_pkg::CMD_ERASE);
            if (cmdWr && isAuto(dataIn)) begin
                busy_ff <= 1'b1; // [RULE3]
            end else if (coreDone) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // flags change only on a command write or on completion
    always_ff @(posedge clock) begin
        if (!nrst) begin
            done_ff <= 1'b0;
            result_ff <= 1'b0;
        end else if (cmdWr) begin
            done_ff <= 1'b0; // [RULE13]
            result_ff <= 1'b0;
        end else if (finish) begin
            done_ff <= 1'b1; // [RULE3]
            result_ff <= !anyFault; // [RULE4] [RULE5]
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            status_ff <= fps_pkg::STATUS_RST; // [RULE2]
        end else if (cmdWr && !isKnown(dataIn)) begin
            status_ff <= fps_pkg::STATUS_RST;
            status_ff[fps_pkg::ST_ABN] <= 1'b1;
            status_ff[fps_pkg::ST_CMDERR] <= 1'b1;
        end else if (cmdWr && isAuto(dataIn)) begin
            status_ff <= fps_pkg::STATUS_RST;
        end else if (finish) begin
            status_ff[fps_pkg::ST_ABN] <= anyFault; // [RULE2]
            status_ff[fps_pkg::ST_PROGF] <= coreFaults[3];
            status_ff[fps_pkg::ST_ERASEF] <= coreFaults[2];
            status_ff[fps_pkg::ST_COUNTF] <= coreFaults[1];
            status_ff[fps_pkg::ST_ADDRF] <= coreFaults[0];
        end
    end

    // pins are driven one cycle after chip and output enables, never while waiting
    always_ff @(posedge clock) begin
        if (!nrst) begin
            dataOut_ff <= 8'h00;
            dataOeN_ff <= 1'b1;
        end else begin
            dataOeN_ff <= !(pinRd && (mode_ff != fps_pkg::MODE_WAIT)); // [RULE6]
            case (mode_ff)
                fps_pkg::MODE_MREAD: dataOut_ff <= arrayData;
                fps_pkg::MODE_PROG, fps_pkg::MODE_ERASE:
                    dataOut_ff <= {done_ff, result_ff, 6'h00}; // [RULE5]
                fps_pkg::MODE_STAT:
                    dataOut_ff <= {status_ff[7:4], 2'b00, status_ff[1:0]}; // [RULE2]
                default: dataOut_ff <= 8'h00;
            endcase
        end
    end

    assign events[fps_pkg::EV_READY] = (mode_ff == fps_pkg::MODE_WAIT) && tmr.setupDone;
    assign events[fps_pkg::EV_DONE] = finish && !anyFault;
    assign events[fps_pkg::EV_FAIL] = finish && anyFault;
    assign events[fps_pkg::EV_IGNORED] = wrEdge && !accepting;

    // a new event wins over the clear made by reading the register
    generate
        for (genvar i = 0; i < fps_pkg::EV_N; i++) begin : gEvent
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    evStat_ff[i] <= 1'b0;
                end else if (events[i]) begin
                    evStat_ff[i] <= 1'b1;
                end else if (statRdClr) begin
                    evStat_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!nrst) begin
            evMask_ff <= fps_pkg::MASK_RST;
        end else if (regWr && (regAddr == fps_pkg::REG_IRQ_MASK)) begin
            evMask_ff <= regWrData[fps_pkg::EV_N-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            regRdData_ff <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                fps_pkg::REG_IRQ_STAT: regRdData_ff <= {4'h0, evStat_ff};
                fps_pkg::REG_IRQ_MASK: regRdData_ff <= {4'h0, evMask_ff};
                fps_pkg::REG_POLL: regRdData_ff <= {done_ff, result_ff, busy_ff,
                                                    mode_ff};
                default: regRdData_ff <= 8'h00;
            endcase
        end else begin
            regRdData_ff <= 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evStat_ff & evMask_ff);
        end
    end

    assign dataOut = dataOut_ff;
    assign dataOeN = dataOeN_ff;
    assign progStart = progStart_ff;
    assign eraseStart = eraseStart_ff;
    assign regRdData = regRdData_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    status_gap_a: assert property ((mode_ff == fps_pkg::MODE_STAT) && pinRd // [RULE2]
        |=> !dataOeN && (dataOut[3:2] == 2'b00) && (dataOut[7] == $past(status_ff[7])))
        else $error("status byte bits wrong on pins");
    busy_poll_a: assert property (busy_ff && !coreDone && pinRd // [RULE3]
        |=> !dataOeN && (dataOut == 8'h00))
        else $error("polling not zero while operating");
    // both flags high can only follow an auto operation, since any command write clears them
    good_end_a: assert property (done_ff && result_ff && pinRd // [RULE4]
        |=> !dataOeN && (dataOut == 8'hc0))
        else $error("normal end not shown as 11");
    bad_end_a: assert property (finish && anyFault |=> done_ff && !result_ff // [RULE5]
        && status_ff[fps_pkg::ST_ABN])
        else $error("abnormal end not shown with one flag");
    wait_ignore_a: assert property ((mode_ff == fps_pkg::MODE_WAIT) && !tmr.setupDone // [RULE6]
        |=> (mode_ff == fps_pkg::MODE_WAIT) && !progStart && dataOeN)
        else $error("command taken during start-up");
    enter_read_a: assert property ((mode_ff == fps_pkg::MODE_WAIT) && tmr.setupDone // [RULE8]
        |=> (mode_ff == fps_pkg::MODE_MREAD))
        else $error("memory read not entered after setup");
    flag_hold_a: assert property (!cmdWr && !finish // [RULE13]
        |=> $stable(done_ff) && $stable(result_ff))
        else $error("polling flags changed without command");
    irq_level_a: assert property (|(evStat_ff & evMask_ff) |=> irq)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// File: verif/fps_core_model.sv
// array sequencer stand-in that answers auto program and auto erase starts
`timescale 1ns/1ps
`default_nettype none
module fps_core_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic progStart,
    input wire logic eraseStart,
    input wire logic [7:0] lat,
    input wire logic [3:0] faultSel,
    output logic coreDone,
    output logic [3:0] coreFaults
);
    logic [8:0] waitCnt_ff;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            waitCnt_ff <= 9'h000;
            coreDone <= 1'b0;
            coreFaults <= 4'h0;
        end else begin
            coreDone <= 1'b0;
            // faults carry no meaning outside the done pulse, so they keep toggling
            coreFaults <= ~coreFaults;
            if (progStart || eraseStart) begin
                waitCnt_ff <= {1'b0, lat};
            end else if (waitCnt_ff == 9'h001) begin
                waitCnt_ff <= 9'h000;
                coreDone <= 1'b1;
                coreFaults <= faultSel;
            end else if (waitCnt_ff != 9'h000) begin
                waitCnt_ff <= waitCnt_ff - 9'h001;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/fps_status_bench.sv
// self-checking bench for the programmer status block
`timescale 1ns/1ps
`default_nettype none
module fps_status_bench;
    localparam int unsigned OSC = 20;
    localparam int unsigned SETUP = 30;
    logic clock, nrst, ceN, oeN, weN, dataOeN, progStart, eraseStart, coreDone;
    logic regWr, regRd, irq;
    logic [7:0] dataIn, dataOut, arrayData, regWrData, regRdData, v, lat;
    logic [1:0] regAddr;
    logic [3:0] coreFaults, faultSel, f;
    logic [31:0] seed;
    int failures, checked, starts, dones, s0, d0;

    fps_status #(.OSC_CYCLES(OSC), .SETUP_CYCLES(SETUP)) DUT (.clock(clock), .nrst(nrst),
        .ceN(ceN), .oeN(oeN), .weN(weN), .dataIn(dataIn), .dataOut(dataOut),
        .dataOeN(dataOeN), .arrayData(arrayData), .progStart(progStart),
        .eraseStart(eraseStart), .coreDone(coreDone), .coreFaults(coreFaults),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq));
    fps_core_model core (.clock(clock), .nrst(nrst), .progStart(progStart),
        .eraseStart(eraseStart), .lat(lat), .faultSel(faultSel), .coreDone(coreDone),
        .coreFaults(coreFaults));

    // program starts count 1, erase starts count 16
    always @(posedge clock) begin
        starts <= starts + int'(progStart) + 16 * int'(eraseStart);
        dones <= dones + int'(coreDone);
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_status(logic [3:0] x);
        return {|x, 1'b0, x[3], x[2], 2'b00, x[1], x[0]};
    endfunction
    function automatic logic [7:0] exp_poll(logic [3:0] x);
        return {1'b1, ~|x, 6'h00};
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cmd(logic [7:0] c);
        @(posedge clock) begin weN <= 1'b0; ceN <= 1'b0; dataIn <= c; end
        @(posedge clock) begin weN <= 1'b1; ceN <= 1'b1; end
        @(posedge clock);
    endtask
    task automatic pin_rd(output logic [7:0] d);
        @(posedge clock) begin ceN <= 1'b0; oeN <= 1'b0; end
        repeat (2) @(posedge clock);
        #1 d = dataOut;
        check("pin drive", {7'h00, dataOeN}, 8'h00);
        @(posedge clock) begin ceN <= 1'b1; oeN <= 1'b1; end
    endtask
    task automatic reg_rd(logic [1:0] a, output logic [7:0] d);
        @(posedge clock) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clock) regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic reg_wr(logic [1:0] a, logic [7:0] d);
        @(posedge clock) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
        @(posedge clock) regWr <= 1'b0;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        finish_test();
    end

    initial begin
        {nrst, regWr, regRd, regAddr, regWrData, dataIn, arrayData, faultSel} = '0;
        {ceN, oeN, weN} = 3'b111;
        lat = 8'h01;
        seed = 32'h0000206d;
        failures = 0;
        checked = 0;
        starts = 0;
        dones = 0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1 check("idle drive", {7'h00, dataOeN}, 8'h01);
        reg_rd(fps_pkg::REG_POLL, v);
        check("mode wait", v, 8'h01);
        cmd(fps_pkg::CMD_PROG);
        check("early start", 8'(starts), 8'h00);
        reg_rd(fps_pkg::REG_IRQ_STAT, v);
        check("ignored event", v & 8'h08, 8'h08);
        // unmapped index swallows writes and reads zero
        reg_wr(2'h3, 8'hff);
        reg_rd(2'h3, v);
        check("unmapped", v, 8'h00);
        $display("start-up test done");
        repeat (OSC + SETUP + 4) @(posedge clock);
        reg_rd(fps_pkg::REG_POLL, v);
        check("mode mread", v, 8'h02);
        reg_rd(fps_pkg::REG_IRQ_STAT, v);
        check("ready event", v & 8'h01, 8'h01);
        @(posedge clock) arrayData <= 8'(xs());
        pin_rd(v);
        check("array read", v, arrayData);
        // erase first, then program, alternating; each block programmed once
        for (int i = 0; i < 6; i++) begin
            f = (i == 0) ? 4'h0 : 4'(xs());
            reg_wr(fps_pkg::REG_IRQ_MASK, (i == 0) ? 8'h00 : 8'h06);
            faultSel <= f;
            lat <= i[1] ? 8'hc8 : 8'h01;
            s0 = starts;
            d0 = dones;
            cmd(i[0] ? fps_pkg::CMD_PROG : fps_pkg::CMD_ERASE);
            // the start counter settles after the edge on which cmd returns
            #1 check("start kind", 8'(starts - s0), i[0] ? 8'h01 : 8'h10);
            if (i[1]) begin
                pin_rd(v);
                check("busy poll", v, 8'h00);
            end
            for (int k = 0; k < 400 && dones == d0; k++) @(posedge clock);
            pin_rd(v);
            check("end poll", v, exp_poll(f));
            repeat (50) @(posedge clock);
            pin_rd(v);
            check("held poll", v, exp_poll(f));
            #1 check("irq level", {7'h00, irq}, (i == 0) ? 8'h00 : 8'h01);
            reg_rd(fps_pkg::REG_IRQ_STAT, v);
            check("done event", v & 8'h06, (f == 4'h0) ? 8'h02 : 8'h04);
            repeat (2) @(posedge clock);
            #1 check("irq clear", {7'h00, irq}, 8'h00);
            cmd(fps_pkg::CMD_STAT);
            repeat (4000) @(posedge clock);
            pin_rd(v);
            check("status byte", v & 8'hf3, exp_status(f));
            $display("operation test %0d done", i);
        end
        cmd(fps_pkg::CMD_MREAD);
        @(posedge clock) arrayData <= 8'(xs());
        pin_rd(v);
        check("back to read", v, arrayData);
        reg_rd(fps_pkg::REG_POLL, v);
        check("flags cleared", v, 8'h02);
        $display("memory read command test done");
        cmd(8'h55);
        repeat (4000) @(posedge clock);
        pin_rd(v);
        check("command error", v & 8'hf3, 8'hc0);
        $display("command error test done");
        finish_test();
    end
endmodule
`default_nettype wire
